// *** event_flags_pkg.sv ***
// event flag word constants: bit positions, reset value, register index
// assumes a serial-port register engine supplies the word's index; the flag module compares it to flags_word_idx
`default_nettype none
package event_flags_pkg;
  localparam logic [15:0] flags_word_idx  = 16'h0403;
  localparam int          flags_w         = 32;
  localparam logic [31:0] flags_rst_val   = 32'h0000_0000;
  localparam int          crc_done_bit    = 27;
  localparam int          checksum_changed_flag_bit     = 26;
  localparam int          sag_lo_bit      = 23;
  localparam int          surge_lo_bit    = 20;
  localparam int          rsvd_bit        = 19;
  localparam int          order_bit       = 18;
  localparam int          overcur_bit     = 17;
  localparam int          powerup_bit     = 16;
  localparam int          icross_lo_bit   = 13;
  localparam int          comb_bit        = 12;
  localparam int          vcross_lo_bit   = 9;
  localparam int          timeout_lo_bit  = 6;
  localparam int          idle_bit        = 5;
  localparam logic [31:0] flag_mask       = 32'h0FF7_FFE0;
endpackage
`default_nettype wire

// *** flag_cell.sv ***
// one sticky write-one-to-clear flag
// assumes set and clear pulses are synchronous to mclk
`default_nettype none
module flag_cell (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  output var  logic flag_q
);
  typedef struct packed {
    logic flag;
  } cell_state_t;
  cell_state_t st_r;
  cell_state_t st_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    st_nxt = st_r;
    if (set_evt) begin
      st_nxt.flag = 1'b1;
    end else if (clr_evt) begin
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_q = st_r.flag;
endmodule
`default_nettype wire

// *** metering_event_status_flags.sv ***
// sticky event flags, bits 27..5 of the first status word
// assumes pulse inputs are one-cycle events in the mclk domain and
// the serial-port engine gives one-cycle write strobes and read strobes
`default_nettype none
module metering_event_status_flags
#(
  parameter int phases = 3
) (
  input  wire logic                                mclk,
  input  wire logic                                rst,
  input  wire logic                                crc_done_evt,
  input  wire logic                                crc_change_evt,
  input  wire logic [phases-1:0]                   sag_change_evt,
  input  wire logic [phases-1:0]                   surge_change_evt,
  input  wire logic                                order_fault_evt,
  input  wire logic                                overcurrent_evt,
  input  wire logic                                powerup_done_evt,
  input  wire logic [phases-1:0]                   current_cross_evt,
  input  wire logic                                comb_cross_evt,
  input  wire logic [phases-1:0]                   voltage_cross_evt,
  input  wire logic [phases-1:0]                   cross_timeout_evt,
  input  wire logic                                idle_change_evt,
  input  wire logic                                wr_en,
  input  wire logic [15:0]                         wr_idx,
  input  wire logic [event_flags_pkg::flags_w-1:0] wr_data,
  input  wire logic                                rd_en,
  input  wire logic [15:0]                         rd_idx,
  output var  logic [event_flags_pkg::flags_w-1:0] rd_data,
  output var  logic                                rd_valid,
  output var  logic [event_flags_pkg::flags_w-1:0] flags_word
);
  import event_flags_pkg::*;

  if (phases != 3) begin : g_bad_phases
    $error("only three phases are laid out in the flag word");
  end

  ////////////////////////////////////////////////////////////////////
  // event and clear vectors

  logic [flags_w-1:0] set_vec;
  logic [flags_w-1:0] clr_vec;
  logic [flags_w-1:0] flag_q;
  logic               wr_hit;

  assign wr_hit = wr_en && (wr_idx == flags_word_idx);

  always_comb begin
    set_vec = '0;
    set_vec[crc_done_bit] = crc_done_evt;
    set_vec[checksum_changed_flag_bit] = crc_change_evt;
    set_vec[sag_lo_bit +: 3] = sag_change_evt;
    set_vec[surge_lo_bit +: 3] = surge_change_evt;
    set_vec[order_bit] = order_fault_evt;
    set_vec[overcur_bit] = overcurrent_evt;
    set_vec[powerup_bit] = powerup_done_evt;
    set_vec[icross_lo_bit +: 3] = current_cross_evt;
    set_vec[comb_bit] = comb_cross_evt;
    set_vec[vcross_lo_bit +: 3] = voltage_cross_evt;
    set_vec[timeout_lo_bit +: 3] = cross_timeout_evt;
    set_vec[idle_bit] = idle_change_evt;
    set_vec = set_vec & flag_mask;
  end

  // write one clears; zero bits leave flags alone
  assign clr_vec = (wr_hit ? wr_data : '0) & flag_mask;

  ////////////////////////////////////////////////////////////////////
  // flag cells, one per implemented bit

  genvar gi;
  generate
    for (gi = 0; gi < flags_w; gi++) begin : g_flag
      if (flag_mask[gi]) begin : g_cell
        flag_cell u_cell (
          .mclk    (mclk),
          .rst     (rst),
          .set_evt (set_vec[gi]),
          .clr_evt (clr_vec[gi]),
          .flag_q  (flag_q[gi])
        );
      end else begin : g_zero
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // read port and mirrored word

  typedef struct packed {
    logic [flags_w-1:0] rd_data;
    logic               rd_valid;
    logic [flags_w-1:0] word;
  } top_state_t;
  top_state_t st_r;
  top_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = rd_en;
    st_nxt.word = flag_q;
    if (rd_en && (rd_idx == flags_word_idx)) begin
      st_nxt.rd_data = flag_q & flag_mask;
    end else if (rd_en) begin
      st_nxt.rd_data = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '{rd_data: flags_rst_val, rd_valid: 1'b0,
                word: flags_rst_val};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data    = st_r.rd_data;
  assign rd_valid   = st_r.rd_valid;
  assign flags_word = st_r.word;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_crc_done_set: assert property (
    crc_done_evt |-> ##2 flags_word[crc_done_bit])
    else $error("checksum done flag not set");
  chk_checksum_changed_flag_set: assert property (
    crc_change_evt |-> ##1 flag_q[checksum_changed_flag_bit] ##1 flags_word[checksum_changed_flag_bit])
    else $error("checksum change flag not set");
  chk_sag_set: assert property (
    sag_change_evt[0] |-> ##1 flag_q[sag_lo_bit])
    else $error("sag flag not set");
  chk_surge_set: assert property (
    surge_change_evt[2] |-> ##1 flag_q[surge_lo_bit + 2])
    else $error("surge flag not set");
  chk_order_set: assert property (
    order_fault_evt |-> ##1 flag_q[order_bit])
    else $error("phase order flag not set");
  chk_overcur_set: assert property (
    overcurrent_evt |-> ##1 flag_q[overcur_bit])
    else $error("overcurrent flag not set");
  chk_powerup_set: assert property (
    powerup_done_evt |-> ##1 flag_q[powerup_bit])
    else $error("power-up flag not set");
  chk_icross_set: assert property (
    current_cross_evt[1] |-> ##1 flag_q[icross_lo_bit + 1])
    else $error("current crossing flag not set");
  chk_comb_set: assert property (
    comb_cross_evt |-> ##1 flag_q[comb_bit])
    else $error("combined crossing flag not set");
  chk_vcross_set: assert property (
    voltage_cross_evt[0] |-> ##1 flag_q[vcross_lo_bit])
    else $error("voltage crossing flag not set");
  chk_timeout_set: assert property (
    cross_timeout_evt[2] |-> ##1 flag_q[timeout_lo_bit + 2])
    else $error("timeout flag not set");
  chk_idle_set: assert property (
    idle_change_evt |-> ##1 flag_q[idle_bit])
    else $error("idle change flag not set");
  chk_sticky_hold: assert property (
    (flag_q[idle_bit] && !(wr_hit && wr_data[idle_bit]))
      |=> flag_q[idle_bit])
    else $error("flag dropped without a write of one");
  chk_w1c_clear: assert property (
    (wr_hit && wr_data[comb_bit] && !comb_cross_evt)
      |=> !flag_q[comb_bit])
    else $error("write one did not clear flag");
  chk_rsvd_zero: assert property (
    !flags_word[rsvd_bit] && !(rd_valid && rd_data[rsvd_bit]))
    else $error("reserved bit seen high");
  chk_read_data: assert property (
    (rd_en && rd_idx == flags_word_idx) |=> rd_data == $past(flag_q))
    else $error("read data does not match flags");

  ////////////////////////////////////////////////////////////////////
  // per-phase, mirror, clear and read checks

  chk_sag_b_set: assert property (
    sag_change_evt[1] |-> ##1 flag_q[sag_lo_bit + 1])
    else $error("phase b sag flag not set");
  chk_sag_c_set: assert property (
    sag_change_evt[2] |-> ##1 flag_q[sag_lo_bit + 2])
    else $error("phase c sag flag not set");
  chk_surge_a_set: assert property (
    surge_change_evt[0] |-> ##1 flag_q[surge_lo_bit])
    else $error("phase a surge flag not set");
  chk_surge_b_set: assert property (
    surge_change_evt[1] |-> ##1 flag_q[surge_lo_bit + 1])
    else $error("phase b surge flag not set");
  chk_icross_a_set: assert property (
    current_cross_evt[0] |-> ##1 flag_q[icross_lo_bit])
    else $error("phase a current crossing flag not set");
  chk_icross_c_set: assert property (
    current_cross_evt[2] |-> ##1 flag_q[icross_lo_bit + 2])
    else $error("phase c current crossing flag not set");
  chk_vcross_b_set: assert property (
    voltage_cross_evt[1] |-> ##1 flag_q[vcross_lo_bit + 1])
    else $error("phase b voltage crossing flag not set");
  chk_vcross_c_set: assert property (
    voltage_cross_evt[2] |-> ##1 flag_q[vcross_lo_bit + 2])
    else $error("phase c voltage crossing flag not set");
  chk_timeout_a_set: assert property (
    cross_timeout_evt[0] |-> ##1 flag_q[timeout_lo_bit])
    else $error("phase a timeout flag not set");
  chk_timeout_b_set: assert property (
    cross_timeout_evt[1] |-> ##1 flag_q[timeout_lo_bit + 1])
    else $error("phase b timeout flag not set");

  chk_sag_word: assert property (
    sag_change_evt[1] |-> ##2 flags_word[sag_lo_bit + 1])
    else $error("sag flag missing from word");
  chk_surge_word: assert property (
    surge_change_evt[0] |-> ##2 flags_word[surge_lo_bit])
    else $error("surge flag missing from word");
  chk_order_word: assert property (
    order_fault_evt |-> ##2 flags_word[order_bit])
    else $error("phase order flag missing from word");
  chk_overcur_word: assert property (
    overcurrent_evt |-> ##2 flags_word[overcur_bit])
    else $error("overcurrent flag missing from word");
  chk_powerup_word: assert property (
    powerup_done_evt |-> ##2 flags_word[powerup_bit])
    else $error("power-up flag missing from word");
  chk_icross_word: assert property (
    current_cross_evt[2] |-> ##2 flags_word[icross_lo_bit + 2])
    else $error("current crossing flag missing from word");
  chk_comb_word: assert property (
    comb_cross_evt |-> ##2 flags_word[comb_bit])
    else $error("combined crossing flag missing from word");
  chk_vcross_word: assert property (
    voltage_cross_evt[1] |-> ##2 flags_word[vcross_lo_bit + 1])
    else $error("voltage crossing flag missing from word");
  chk_timeout_word: assert property (
    cross_timeout_evt[0] |-> ##2 flags_word[timeout_lo_bit])
    else $error("timeout flag missing from word");
  chk_idle_word: assert property (
    idle_change_evt |-> ##2 flags_word[idle_bit])
    else $error("idle change flag missing from word");

  chk_set_wins: assert property (
    (wr_hit && wr_data[idle_bit] && idle_change_evt)
      |=> flag_q[idle_bit])
    else $error("clear beat a same-cycle event");
  chk_zero_write_keep: assert property (
    (wr_hit && !wr_data[crc_done_bit] && flag_q[crc_done_bit])
      |=> flag_q[crc_done_bit])
    else $error("zero write cleared a flag");
  chk_other_idx_keep: assert property (
    (wr_en && (wr_idx != flags_word_idx) && flag_q[idle_bit])
      |=> flag_q[idle_bit])
    else $error("write to another index cleared a flag");
  chk_clear_all: assert property (
    (wr_hit && ((wr_data & flag_mask) == flag_mask) && (set_vec == '0))
      |=> (flag_q == '0))
    else $error("full clear left a flag set");
  chk_no_spurious: assert property (
    (!set_vec[crc_done_bit] && !flag_q[crc_done_bit])
      |=> !flag_q[crc_done_bit])
    else $error("checksum done flag rose with no event");

  chk_mirror_lag: assert property (
    flags_word == $past(flag_q))
    else $error("mirrored word does not follow flags");
  chk_rd_valid_pulse: assert property (
    rd_valid == $past(rd_en))
    else $error("read valid not one cycle after strobe");
  chk_other_idx_zero: assert property (
    (rd_en && (rd_idx != flags_word_idx)) |=> (rd_data == '0))
    else $error("read of another index not zero");
  chk_read_stable: assert property (
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without a strobe");
  chk_unmapped_zero: assert property (
    (flags_word & ~flag_mask) == '0)
    else $error("unmapped bit seen high in word");

  cov_clear_then_set: cover property (
    wr_hit && wr_data[powerup_bit] ##1 powerup_done_evt);
  cov_set_clear_same: cover property (
    wr_hit && wr_data[overcur_bit] && overcurrent_evt);
  cov_read_all_set: cover property (rd_valid && rd_data == flag_mask);
  cov_other_idx_read: cover property (
    rd_en && (rd_idx != flags_word_idx));
  cov_set_wins_idle: cover property (
    wr_hit && wr_data[idle_bit] && idle_change_evt);
endmodule
`default_nettype wire

// *** host_model.sv ***
// host model: reads and writes the flag word on the register strobes
// assumes the bench clock; host drives only at falling edges
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [31:0] flags_word,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid,
  output var  logic        wr_en,
  output var  logic [15:0] wr_idx,
  output var  logic [31:0] wr_data,
  output var  logic        rd_en,
  output var  logic [15:0] rd_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  import event_flags_pkg::*;
  logic up_r;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_idx = 16'h0000;
    rd_idx = 16'h0000;
    wr_data = 32'h0000_0000;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) up_r <= 1'b0;
    else if (flags_word[powerup_bit] === 1'b1) up_r <= 1'b1;
  end
  task automatic wr(input logic [15:0] i, input logic [31:0] v);
    for (int k = 0; k < 50 && up_r !== 1'b1; k++) @(negedge mclk);
    @(negedge mclk);
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = v;
    @(negedge mclk);
    wr_en = 1'b0;
    wr_idx = ~i;
    wr_data = ~v;
  endtask
  task automatic rd(input logic [15:0] i, output logic [31:0] v);
    v = 32'hxxxx_xxxx;
    @(negedge mclk);
    rd_en = 1'b1;
    rd_idx = i;
    @(negedge mclk);
    rd_en = 1'b0;
    rd_idx = ~i;
    for (int k = 0; k < 4; k++) begin
      if (rd_valid === 1'b1) begin
        v = rd_data;
        break;
      end
      @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// *** metering_event_status_flags_tb.sv ***
// bench for the sticky event flag word
// assumes host_model supplies the register access tasks
`default_nettype none
module metering_event_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import event_flags_pkg::*;
  logic mclk, rst, wr_en, rd_en, rd_valid;
  logic [15:0] wr_idx, rd_idx;
  logic [31:0] ev, wr_data, rd_data, flags_word, d;
  int miscompares, tests_run, cyc;
  metering_event_status_flags dut (
    .mclk(mclk), .rst(rst), .crc_done_evt(ev[27]),
    .crc_change_evt(ev[26]), .sag_change_evt(ev[25:23]),
    .surge_change_evt(ev[22:20]), .order_fault_evt(ev[18]),
    .overcurrent_evt(ev[17]), .powerup_done_evt(ev[16]),
    .current_cross_evt(ev[15:13]), .comb_cross_evt(ev[12]),
    .voltage_cross_evt(ev[11:9]), .cross_timeout_evt(ev[8:6]),
    .idle_change_evt(ev[5]), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .rd_en(rd_en), .rd_idx(rd_idx),
    .rd_data(rd_data), .rd_valid(rd_valid), .flags_word(flags_word));
  host_model h (
    .mclk(mclk), .rst(rst), .flags_word(flags_word), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .rd_en(rd_en), .rd_idx(rd_idx));
  always #2 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [31:0] e);
    h.rd(flags_word_idx, d);
    cmp(d, e);
  endtask
  task automatic pulse(input logic [31:0] m);
    @(negedge mclk);
    ev = m;
    @(negedge mclk);
    ev = 32'h0000_0000;
    repeat (3) @(negedge mclk);
  endtask
  task automatic wrw(input logic [15:0] i, input logic [31:0] v);
    h.wr(i, v);
    repeat (3) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ev = 32'h0000_0000;
    cyc = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    rdc(32'h0000_0000);
    cmp(flags_word, 32'h0000_0000);
    $display("test reset done");
    pulse(32'h0001_0000);
    rdc(32'h0001_0000);
    for (int b = 5; b < 28; b++) begin
      if (b == rsvd_bit) continue;
      wrw(flags_word_idx, flag_mask);
      pulse(32'h0000_0001 << b);
      rdc(32'h0000_0001 << b);
      cmp(flags_word, 32'h0000_0001 << b);
    end
    $display("test each flag done");
    pulse(32'h0800_0020);
    wrw(flags_word_idx, 32'h0000_0000);
    rdc(32'h0800_0020);
    wrw(flags_word_idx, 32'h0800_0000);
    rdc(32'h0000_0020);
    wrw(16'h0404, flag_mask);
    rdc(32'h0000_0020);
    $display("test clear done");
    wrw(flags_word_idx, 32'hFFFF_FFFF);
    rdc(32'h0000_0000);
    pulse(32'hFFFF_FFFF);
    rdc(flag_mask);
    h.rd(16'h0404, d);
    cmp(d, 32'h0000_0000);
    $display("test reserved done");
    fork
      pulse(32'h0000_0020);
      wrw(flags_word_idx, flag_mask);
    join
    rdc(32'h0000_0020);
    $display("test set wins done");
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rdc(32'h0000_0000);
    cmp(flags_word, 32'h0000_0000);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
